/* File: core/cisd_pkg.sv */
// package of operation classes, lengths and timing for the instruction decoder
package cisd_pkg;
    localparam int unsigned CISD_CLK_HZ = 25000000;
    localparam int unsigned CISD_LEN_SHORT = 2;
    localparam int unsigned CISD_LEN_LONG = 4;
    localparam logic [3:0] CISD_INIT_SETTLE_NS = 4'h8;
    localparam logic [1:0] CISD_RST_PWR = 2'h0;
    localparam logic [1:0] CISD_RST_INIT = 2'h0;
    localparam logic [15:0] CISD_RST_WORD = 16'h0000;
    localparam logic [15:0] CISD_SIGN_BIT = 16'h8000;
    typedef enum logic [5:0] {
        CISD_OP_NOP, CISD_OP_ADD, CISD_OP_ADDC, CISD_OP_SUB, CISD_OP_SUBC,
        CISD_OP_MUL, CISD_OP_UMUL, CISD_OP_DIV, CISD_OP_DIVU, CISD_OP_LDIV, CISD_OP_LDIVU,
        CISD_OP_CPL, CISD_OP_NEG, CISD_OP_AND, CISD_OP_OR, CISD_OP_XOR,
        CISD_OP_BCLR, CISD_OP_BSET, CISD_OP_BITCOPY, CISD_OP_BITCOPYN, CISD_OP_BITLOGIC,
        CISD_OP_BITCMP, CISD_OP_MASK_HI, CISD_OP_MASK_LO, CISD_OP_CMP,
        CISD_OP_CMP_DEC1, CISD_OP_CMP_DEC2, CISD_OP_CMP_INC1, CISD_OP_CMP_INC2, CISD_OP_NORM_CNT,
        CISD_OP_SHL, CISD_OP_SHR, CISD_OP_ROL, CISD_OP_ROR, CISD_OP_SIGN_SHR, CISD_OP_MOV,
        CISD_OP_MOVSX, CISD_OP_MOVZX, CISD_OP_JMP, CISD_OP_JMPSEG, CISD_OP_JBIT,
        CISD_OP_JCLRBIT, CISD_OP_JSETBIT, CISD_OP_CALL, CISD_OP_CALLSEG, CISD_OP_PUSH_CALL,
        CISD_OP_TRAP, CISD_OP_PUSH, CISD_OP_POP, CISD_OP_CTXSW, CISD_OP_RET, CISD_OP_RETS,
        CISD_OP_RETPOP, CISD_OP_RETI, CISD_OP_SRST, CISD_OP_IDLE, CISD_OP_POWER_DOWN,
        CISD_OP_SRVWDT, CISD_OP_DISWDT, CISD_OP_END_INIT, CISD_OP_ATOMIC, CISD_OP_EXTREG,
        CISD_OP_EXTPAGE, CISD_OP_EXTSEG
    } cisd_op_t;
    // one bit wider than the class field so the count of 64 classes fits
    localparam logic [6:0] CISD_OP_COUNT = 7'h40;
    typedef enum logic [2:0] {
        CISD_ST_IDLE = 3'b001,
        CISD_ST_WAIT_HI = 3'b010,
        CISD_ST_BUSY = 3'b100
    } cisd_state_t;
endpackage : cisd_pkg

/* File: core/cisd_opmap.sv */
// combinational opcode table: opcode byte to class, length and execution flags
module cisd_opmap
    import cisd_pkg::*;
(
    input wire logic [7:0] opcode,
    output cisd_op_t op,
    output logic long_form,
    output logic variant,
    output logic known
);
    // the upper 6 bits pick the class; bit 1 chooses long form where the class has no fixed length, bit 0 the variant
    always_comb begin
        op = cisd_op_t'(opcode[7:2]);
        known = ({1'b0, opcode[7:2]} < CISD_OP_COUNT);
        variant = opcode[0];
        case (op)
            CISD_OP_MUL, CISD_OP_UMUL, CISD_OP_DIV, CISD_OP_DIVU, CISD_OP_LDIV, CISD_OP_LDIVU,
            CISD_OP_CPL, CISD_OP_NEG, CISD_OP_BCLR, CISD_OP_BSET, CISD_OP_NORM_CNT,
            CISD_OP_SHL, CISD_OP_SHR, CISD_OP_ROL, CISD_OP_ROR, CISD_OP_SIGN_SHR, CISD_OP_TRAP,
            CISD_OP_PUSH, CISD_OP_POP, CISD_OP_RET, CISD_OP_RETS, CISD_OP_RETPOP, CISD_OP_RETI,
            CISD_OP_ATOMIC, CISD_OP_EXTREG, CISD_OP_NOP: long_form = 1'b0;
            CISD_OP_BITCOPY, CISD_OP_BITCOPYN, CISD_OP_BITLOGIC, CISD_OP_BITCMP, CISD_OP_MASK_HI,
            CISD_OP_MASK_LO, CISD_OP_JMP, CISD_OP_JMPSEG, CISD_OP_JBIT, CISD_OP_JCLRBIT,
            CISD_OP_JSETBIT, CISD_OP_CALL, CISD_OP_CALLSEG, CISD_OP_PUSH_CALL, CISD_OP_CTXSW,
            CISD_OP_SRST, CISD_OP_IDLE, CISD_OP_POWER_DOWN, CISD_OP_SRVWDT, CISD_OP_DISWDT,
            CISD_OP_END_INIT: long_form = 1'b1;
            default: long_form = opcode[1];
        endcase
    end
endmodule : cisd_opmap

/* File: core/cisd_decoder.sv */
// standard instruction decoder with its small execute side-effects
// Function
// - word/byte add, with carry variant, 2 or 4 bytes by operand form
// - word/byte subtract, with carry variant, 2 or 4 bytes
// - signed/unsigned 16x16 register multiply, 2 bytes
// - divide low muldiv half by a register, signed or unsigned, 2 bytes
// - long divide full muldiv by a register, 32/16, signed or unsigned
// - copy one direct bit to another, optionally inverted, 4 bytes
// - masked modify of high or low byte with immediate data, 4 bytes
// - compare word with register then decrement it by 1 or 2
// - compare word with register then increment it by 1 or 2
// - count shifts needed to normalize a word, store count in a register
// - arithmetic right shift keeps sign; logical shifts and rotates, 2 bytes
// - byte to word move, sign-extended or zero-extended upper byte
// - jump relative if bit set and clear that bit, 4 bytes
// - jump relative if bit clear and set that bit, 4 bytes
// - push direct register then absolute call, single 4-byte instruction
// - save direct register on stack then load it with operand, 4 bytes
// - intra-segment return and pop direct register, 2 bytes
// - software interrupt via immediate trap number, 2 bytes
// - power-down entered only while the nmi pin is low, 4 bytes
// - end-of-init raises the reset output pin, 4 bytes
// - extended page sequence, optionally with extended register, 2 or 4 bytes
// - extended segment sequence, optionally with extended register, 2 or 4 bytes
module cisd_decoder
    import cisd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic fetch_valid,
    input wire logic [15:0] fetch_word,
    input wire logic [15:0] operand_word,
    input wire logic [15:0] general_register,
    input wire logic nmi_pin,
    output logic fetch_ready,
    output logic dec_valid,
    output cisd_op_t dec_op,
    output logic dec_long,
    output logic [2:0] dec_len,
    output logic [15:0] dec_result,
    output logic [7:0] trap_number,
    output logic [3:0] bit_update,
    output logic power_down,
    output logic reset_output_pin
);
    cisd_op_t map_op;
    logic map_long;
    logic map_var;
    logic map_known;
    cisd_state_t st_q, st_d;
    logic [15:0] first_q, first_d;
    logic [15:0] second_q, second_d;
    logic dv_q, dv_d;
    cisd_op_t op_q, op_d;
    logic long_q, long_d;
    logic [2:0] len_q, len_d;
    logic [15:0] res_q, res_d;
    logic [7:0] trap_q, trap_d;
    logic [3:0] bit_q, bit_d;
    logic pd_q, pd_d;
    logic init_q, init_d;
    logic rdy_q, rdy_d;
    logic [4:0] normalize_count_op_cnt;
    logic [15:0] word_in;
    logic [15:0] hi_word;
    logic [7:0] opcode_in;

    // once the first word is taken the bus may move on, so decode from the held copy
    assign opcode_in = (st_q == CISD_ST_IDLE) ? fetch_word[7:0] : first_q[7:0];

    cisd_opmap u_opmap (
        .opcode(opcode_in),
        .op(map_op),
        .long_form(map_long),
        .variant(map_var),
        .known(map_known)
    );

    // leading-zero count: one generate-free loop, a priority search from the top
    always_comb begin
        normalize_count_op_cnt = 5'h00;
        for (int i = 15; i >= 0; i--) begin
            if (normalize_count_op_cnt == 5'(15 - i) && general_register[i] == 1'b0) begin
                normalize_count_op_cnt = 5'(16 - i);
            end
        end
        if (general_register == CISD_RST_WORD) begin
            normalize_count_op_cnt = 5'h00;
        end
    end

    assign word_in = operand_word;
    assign hi_word = second_q;

    always_comb begin
        st_d = st_q;
        first_d = first_q;
        second_d = second_q;
        dv_d = 1'b0;
        op_d = op_q;
        long_d = long_q;
        len_d = len_q;
        res_d = res_q;
        trap_d = trap_q;
        bit_d = 4'h0;
        pd_d = pd_q;
        init_d = init_q;
        rdy_d = 1'b1;
        case (st_q)
            CISD_ST_IDLE: begin
                // words offered while ready is low are refused, power-down included
                if (fetch_valid && rdy_q) begin
                    first_d = fetch_word;
                    if (map_long) begin
                        st_d = CISD_ST_WAIT_HI;
                    end else begin
                        st_d = CISD_ST_BUSY;
                        rdy_d = 1'b0;
                    end
                end
            end
            CISD_ST_WAIT_HI: begin
                if (fetch_valid && rdy_q) begin
                    second_d = fetch_word;
                    st_d = CISD_ST_BUSY;
                    rdy_d = 1'b0;
                end
            end
            CISD_ST_BUSY: begin
                // a decode is issued once the whole instruction is held
                dv_d = 1'b1;
                op_d = map_op;
                long_d = map_long;
                len_d = map_long ? 3'(CISD_LEN_LONG) : 3'(CISD_LEN_SHORT);
                res_d = word_in;
                trap_d = first_q[15:8];
                st_d = CISD_ST_IDLE;
                case (map_op)
                    CISD_OP_ADD, CISD_OP_ADDC: res_d = general_register + word_in;
                    CISD_OP_SUB, CISD_OP_SUBC: res_d = general_register - word_in;
                    CISD_OP_MUL, CISD_OP_UMUL, CISD_OP_DIV, CISD_OP_DIVU: res_d = general_register;
                    CISD_OP_LDIV, CISD_OP_LDIVU: res_d = general_register;
                    CISD_OP_BITCOPY: bit_d = {2'b10, word_in[0], 1'b0};
                    CISD_OP_BITCOPYN: bit_d = {2'b10, ~word_in[0], 1'b0};
                    CISD_OP_MASK_HI: res_d = (word_in & ~{hi_word[7:0], 8'h00}) |
                        ({hi_word[15:8], 8'h00} & {hi_word[7:0], 8'h00});
                    CISD_OP_MASK_LO: res_d = (word_in & ~{8'h00, hi_word[7:0]}) |
                        ({8'h00, hi_word[15:8]} & {8'h00, hi_word[7:0]});
                    CISD_OP_CMP_DEC1: res_d = general_register - 16'h0001;
                    CISD_OP_CMP_DEC2: res_d = general_register - 16'h0002;
                    CISD_OP_CMP_INC1: res_d = general_register + 16'h0001;
                    CISD_OP_CMP_INC2: res_d = general_register + 16'h0002;
                    CISD_OP_NORM_CNT: res_d = {11'h000, normalize_count_op_cnt};
                    CISD_OP_SHL: res_d = general_register << word_in[3:0];
                    CISD_OP_SHR: res_d = general_register >> word_in[3:0];
                    CISD_OP_ROL: res_d = (general_register << word_in[3:0]) |
                        (general_register >> (5'h10 - {1'b0, word_in[3:0]}));
                    CISD_OP_ROR: res_d = (general_register >> word_in[3:0]) |
                        (general_register << (5'h10 - {1'b0, word_in[3:0]}));
                    CISD_OP_SIGN_SHR: res_d = 16'($signed(general_register) >>> word_in[3:0]);
                    CISD_OP_MOVSX: res_d = {{8{word_in[7]}}, word_in[7:0]};
                    CISD_OP_MOVZX: res_d = {8'h00, word_in[7:0]};
                    CISD_OP_JCLRBIT: if (word_in[0]) bit_d = 4'b1100;
                    CISD_OP_JSETBIT: if (!word_in[0]) bit_d = 4'b1110;
                    CISD_OP_PUSH_CALL: res_d = general_register;
                    CISD_OP_CTXSW: res_d = word_in;
                    CISD_OP_RETPOP: res_d = word_in;
                    CISD_OP_TRAP: trap_d = first_q[15:8];
                    CISD_OP_POWER_DOWN: pd_d = !nmi_pin;
                    CISD_OP_END_INIT: init_d = 1'b1;
                    CISD_OP_EXTPAGE: res_d = {15'h0000, map_var};
                    CISD_OP_EXTSEG: res_d = {15'h0000, map_var};
                    default: res_d = word_in;
                endcase
                if (!map_known) begin
                    op_d = CISD_OP_NOP;
                end
            end
            default: begin
                st_d = CISD_ST_IDLE;
            end
        endcase
        // a wake from power-down: the nmi pin high releases the core
        if (pd_q && nmi_pin) begin
            pd_d = 1'b0;
        end
        if (pd_q) begin
            rdy_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= CISD_ST_IDLE;
            first_q <= CISD_RST_WORD;
            second_q <= CISD_RST_WORD;
            dv_q <= 1'b0;
            op_q <= CISD_OP_NOP;
            long_q <= 1'b0;
            len_q <= 3'h0;
            res_q <= CISD_RST_WORD;
            trap_q <= 8'h00;
            bit_q <= 4'h0;
            pd_q <= 1'b0;
            init_q <= 1'b0;
            rdy_q <= 1'b0;
        end else if (clk_en) begin
            st_q <= st_d;
            first_q <= first_d;
            second_q <= second_d;
            dv_q <= dv_d;
            op_q <= op_d;
            long_q <= long_d;
            len_q <= len_d;
            res_q <= res_d;
            trap_q <= trap_d;
            bit_q <= bit_d;
            pd_q <= pd_d;
            init_q <= init_d;
            rdy_q <= rdy_d;
        end
    end

    assign fetch_ready = rdy_q;
    assign dec_valid = dv_q;
    assign dec_op = op_q;
    assign dec_long = long_q;
    assign dec_len = len_q;
    assign dec_result = res_q;
    assign trap_number = trap_q;
    assign bit_update = bit_q;
    assign power_down = pd_q;
    assign reset_output_pin = init_q;

    a_len_matches_form: assert property (@(posedge clk) disable iff (!rst_n)
        dec_valid |-> dec_len == (dec_long ? 3'h4 : 3'h2)) else $error("length mismatch");
    a_pdown_needs_nmi: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && $rose(power_down) |-> $past(!nmi_pin)) else $error("power-down without nmi low");
    a_init_sticks: assert property (@(posedge clk) disable iff (!rst_n)
        reset_output_pin |=> reset_output_pin) else $error("reset output dropped");
    a_init_cause: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(reset_output_pin) |-> dec_valid && dec_op == CISD_OP_END_INIT) else $error("init without op");
    a_long_takes_two: assert property (@(posedge clk) disable iff (!rst_n)
        dec_valid && dec_long |-> $past(st_q, 2) == CISD_ST_WAIT_HI || !$past(clk_en))
        else $error("long op skipped second word");
    a_zx_upper_zero: assert property (@(posedge clk) disable iff (!rst_n)
        dec_valid && dec_op == CISD_OP_MOVZX |-> dec_result[15:8] == 8'h00) else $error("zero extend");
    a_sx_upper_sign: assert property (@(posedge clk) disable iff (!rst_n)
        dec_valid && dec_op == CISD_OP_MOVSX |-> dec_result[15:8] == {8{dec_result[7]}})
        else $error("sign extend");
    a_jclr_clears: assert property (@(posedge clk) disable iff (!rst_n)
        dec_valid && dec_op == CISD_OP_JCLRBIT && bit_update[3] |-> bit_update[1] == 1'b0)
        else $error("bit not cleared");
    a_jset_sets: assert property (@(posedge clk) disable iff (!rst_n)
        dec_valid && dec_op == CISD_OP_JSETBIT && bit_update[3] |-> bit_update[1] == 1'b1)
        else $error("bit not set");
    c_long_decode: cover property (@(posedge clk) disable iff (!rst_n) dec_valid && dec_long);
    c_short_decode: cover property (@(posedge clk) disable iff (!rst_n) dec_valid && !dec_long);
    c_power_down: cover property (@(posedge clk) disable iff (!rst_n) $rose(power_down));
    c_init_done: cover property (@(posedge clk) disable iff (!rst_n) $rose(reset_output_pin));
endmodule : cisd_decoder

/* File: tb/cisd_fetch_model.sv */
// fetch unit model: offers instruction words and holds each until taken
module cisd_fetch_model (
    input wire logic clk,
    input wire logic fetch_ready,
    output logic fetch_valid,
    output logic [15:0] fetch_word
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        fetch_valid = 1'b0;
        fetch_word = 16'h0000;
    end
    // word stays put until a sampling edge sees ready high
    task automatic put(input logic [15:0] w);
        fetch_valid = 1'b1;
        fetch_word = w;
        while (fetch_ready !== 1'b1) @(negedge clk);
        @(negedge clk);
    endtask : put
    // released bus shows the inverse so a stale word cannot pass as fresh
    task automatic drop(input int gap);
        fetch_valid = 1'b0;
        fetch_word = ~fetch_word;
        repeat (gap) @(negedge clk);
    endtask : drop
endmodule : cisd_fetch_model

/* File: tb/tb.sv */
// self-checking bench for the instruction decoder
module tb
    import cisd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic nmi_pin = 1'b1;
    logic [15:0] opnd = 16'h0000;
    logic [15:0] gr = 16'h0000;
    logic fetch_valid, fetch_ready, dec_valid, dec_long, power_down, rop;
    logic [15:0] fetch_word, dec_result;
    cisd_op_t dec_op;
    logic [2:0] dec_len;
    logic [7:0] trap_number;
    logic [3:0] bit_update;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    always #20 clk = ~clk;
    cisd_fetch_model fm (.clk(clk), .fetch_ready(fetch_ready), .fetch_valid(fetch_valid), .fetch_word(fetch_word));
    cisd_decoder DUT (.clk(clk), .rst_n(rst_n), .clk_en(1'b1), .fetch_valid(fetch_valid),
        .fetch_word(fetch_word), .operand_word(opnd), .general_register(gr), .nmi_pin(nmi_pin),
        .fetch_ready(fetch_ready), .dec_valid(dec_valid), .dec_op(dec_op), .dec_long(dec_long),
        .dec_len(dec_len), .dec_result(dec_result), .trap_number(trap_number),
        .bit_update(bit_update), .power_down(power_down), .reset_output_pin(rop));
    task automatic results;
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // sends one instruction, optionally with a slow second word, then waits for the decode
    task automatic issue(input cisd_op_t op, input logic lng, input logic v, input logic [7:0] hi,
        input logic [15:0] w2, input int gap);
        int n;
        n = 0;
        fm.put({hi, op, lng, v});
        if (lng) begin
            if (gap > 0) fm.drop(gap);
            fm.put(w2);
        end
        fm.drop(0);
        while (dec_valid !== 1'b1 && n < 12) begin
            @(negedge clk);
            n++;
        end
        chk(16'(n < 12), 16'h0001);
        chk(16'(dec_op), 16'(op));
        chk(16'({dec_long, dec_len}), lng ? 16'h000c : 16'h0002);
    endtask : issue
    task automatic res(input cisd_op_t op, input logic lng, input logic [15:0] w2, input int gap,
        input logic [15:0] g, input logic [15:0] o, input logic [15:0] exp);
        gr = g;
        opnd = o;
        issue(op, lng, 1'b0, 8'h00, w2, gap);
        chk(dec_result, exp);
    endtask : res
    task automatic t_arith;
        res(CISD_OP_ADD, 1'b0, 16'h0000, 0, 16'h1234, 16'h0f0f, 16'h2143);
        res(CISD_OP_ADD, 1'b1, 16'h8001, 3, 16'h7fff, 16'h8001, 16'h0000);
        res(CISD_OP_SUB, 1'b0, 16'h0000, 0, 16'h1000, 16'h0001, 16'h0fff);
        issue(CISD_OP_ADDC, 1'b1, 1'b0, 8'h00, 16'h0001, 0);
        issue(CISD_OP_SUBC, 1'b0, 1'b0, 8'h00, 16'h0000, 0);
    endtask : t_arith
    task automatic t_fixed;
        // the execution unit does the arithmetic, so the register passes through
        for (int i = 0; i < 6; i++) begin
            res(cisd_op_t'(CISD_OP_MUL + i), 1'b0, 16'h0000, 0, 16'hbeef, 16'h0003, 16'hbeef);
        end
        issue(CISD_OP_PUSH_CALL, 1'b1, 1'b0, 8'h00, 16'h1200, 2);
        issue(CISD_OP_CTXSW, 1'b1, 1'b0, 8'h00, 16'h0040, 0);
        issue(CISD_OP_RETPOP, 1'b0, 1'b0, 8'h00, 16'h0000, 0);
    endtask : t_fixed
    task automatic t_step;
        logic [15:0] exp [4] = '{16'h0000, 16'hffff, 16'h0002, 16'h0003};
        for (int i = 0; i < 4; i++) begin
            res(cisd_op_t'(CISD_OP_CMP_DEC1 + i), i[0], 16'h0001, 0, 16'h0001, 16'h0001, exp[i]);
        end
    endtask : t_step
    task automatic t_shift;
        res(CISD_OP_SIGN_SHR, 1'b0, 16'h0000, 0, 16'h8004, 16'h0002, 16'he001);
        res(CISD_OP_SHR, 1'b0, 16'h0000, 0, 16'h8004, 16'h0002, 16'h2001);
        res(CISD_OP_NORM_CNT, 1'b0, 16'h0000, 0, 16'h0010, 16'h0000, 16'h000b);
        res(CISD_OP_NORM_CNT, 1'b0, 16'h0000, 0, 16'h0000, 16'h0000, 16'h0000);
        res(CISD_OP_MOVSX, 1'b1, 16'h3c85, 0, 16'h0000, 16'h3c85, 16'hff85);
        res(CISD_OP_MOVZX, 1'b0, 16'h0000, 0, 16'h0000, 16'hc385, 16'h0085);
    endtask : t_shift
    task automatic bitop(input cisd_op_t op, input logic [15:0] o, input logic [1:0] exp);
        opnd = o;
        issue(op, 1'b1, 1'b0, 8'h00, 16'h0000, 0);
        chk(16'({bit_update[3], bit_update[1]}), 16'(exp));
    endtask : bitop
    task automatic t_bits;
        res(CISD_OP_MASK_LO, 1'b1, 16'h3c0f, 0, 16'h0000, 16'h5aa5, 16'h5aac);
        res(CISD_OP_MASK_HI, 1'b1, 16'h3c0f, 1, 16'h0000, 16'h5aa5, 16'h5ca5);
        bitop(CISD_OP_BITCOPY, 16'h0001, 2'b11);
        bitop(CISD_OP_BITCOPYN, 16'h0001, 2'b10);
        bitop(CISD_OP_JCLRBIT, 16'h0001, 2'b10);
        bitop(CISD_OP_JSETBIT, 16'h0000, 2'b11);
    endtask : t_bits
    task automatic t_sys;
        int n;
        n = 0;
        issue(CISD_OP_TRAP, 1'b0, 1'b0, 8'h2a, 16'h0000, 0);
        chk(16'(trap_number), 16'h002a);
        issue(CISD_OP_END_INIT, 1'b1, 1'b0, 8'h00, 16'h0000, 0);
        repeat (5) @(negedge clk);
        chk(16'(rop), 16'h0001);
        issue(CISD_OP_POWER_DOWN, 1'b1, 1'b0, 8'h00, 16'h0000, 0);
        repeat (2) @(negedge clk);
        chk(16'(power_down), 16'h0000);
        nmi_pin = 1'b0;
        issue(CISD_OP_POWER_DOWN, 1'b1, 1'b0, 8'h00, 16'h0000, 0);
        repeat (2) @(negedge clk);
        chk(16'({power_down, fetch_ready}), 16'h0002);
        nmi_pin = 1'b1;
        while (power_down !== 1'b0 && n < 6) begin
            @(negedge clk);
            n++;
        end
        chk(16'(n < 6), 16'h0001);
        for (int i = 0; i < 4; i++) begin
            issue(i[1] ? CISD_OP_EXTSEG : CISD_OP_EXTPAGE, i[0], i[0], 8'h03, 16'h0001, 0);
            chk(dec_result, 16'(i[0]));
        end
        rst_n = 1'b0;
        @(negedge clk);
        chk(16'(rop), 16'h0000);
        rst_n = 1'b1;
    endtask : t_sys
    // hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            results();
        end
    end
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        t_arith();
        t_fixed();
        t_step();
        t_shift();
        t_bits();
        t_sys();
        results();
    end
endmodule : tb
